// *** hdl/sfc_flash_seq.sv ***
// Serial configuration flash: command framing, self-timed cycles, power mode
`timescale 1ns/1ps
// Overview of operation
// - Select low means enabled, active power
// - Stay active until internal cycles finish
// - Small parts program page within 5 ms
// - Largest part programs page within 7 ms
// - Status write cycle within 15 ms
// - Full erase within density dependent maximum
// - Sector erase within 3 or 6 s
// - Busy bit reads 1 during cycles
// - Write enable latch cleared each cycle
// - Cycle starts as select goes high
module sfc_flash_seq
    import sfc_pkg::*;
#(
    parameter int DENSITY = LARGEST_DENSITY,
    parameter bit USE_MAX = 1'b1,
    parameter logic [TIME_W-1:0] PAGE_PROGRAM_US = (DENSITY == LARGEST_DENSITY) ?
        TIME_W'($rtoi((USE_MAX ? PAGE_PROGRAM_MAX_LARGE_MS : PAGE_PROGRAM_TYP_LARGE_MS) * US_PER_MS)) :
        TIME_W'($rtoi((USE_MAX ? PAGE_PROGRAM_MAX_SMALL_MS : PAGE_PROGRAM_TYP_SMALL_MS) * US_PER_MS)),
    parameter logic [TIME_W-1:0] STATUS_WRITE_US =
        TIME_W'((USE_MAX ? STATUS_WRITE_MAX_MS : STATUS_WRITE_TYP_MS) * US_PER_MS),
    parameter logic [TIME_W-1:0] FULL_ERASE_US =
        TIME_W'((USE_MAX ? FULL_ERASE_MAX_S[DENSITY] : FULL_ERASE_TYP_S[DENSITY]) * US_PER_S),
    parameter logic [TIME_W-1:0] SECTOR_ERASE_US = TIME_W'((USE_MAX ?
        ((DENSITY == LARGEST_DENSITY) ? SECTOR_ERASE_MAX_LARGE_S : SECTOR_ERASE_MAX_SMALL_S) :
        SECTOR_ERASE_TYP_S) * US_PER_S)
) (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic MEMORY_SELECT_N_IN,
    input wire logic SERIAL_CLOCK_LINE_IN,
    input wire logic SERIAL_IN_LINE_IN,
    output logic DATA_OUT,
    output logic DATA_OE_OUT,
    output logic ACTIVE_POWER_OUT,
    output logic WRITE_IN_PROGRESS_OUT,
    output logic WRITE_ENABLE_LATCH_OUT
);
    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [SYN_W-1:0] sync1_q, sync2_q, prev_q;
    logic sel_low, sel_fall, sel_rise, sclk_rise, sclk_fall;

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            sync1_q <= SYN_RESET;
            sync2_q <= SYN_RESET;
            prev_q <= SYN_RESET;
        end else begin
            sync1_q <= {SERIAL_IN_LINE_IN, SERIAL_CLOCK_LINE_IN, MEMORY_SELECT_N_IN};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign sel_low = ~sync2_q[SYN_SEL];
    assign sel_fall = ~sync2_q[SYN_SEL] & prev_q[SYN_SEL];
    assign sel_rise = sync2_q[SYN_SEL] & ~prev_q[SYN_SEL];
    assign sclk_rise = sync2_q[SYN_CLK] & ~prev_q[SYN_CLK];
    assign sclk_fall = ~sync2_q[SYN_CLK] & prev_q[SYN_CLK];

    // ------------------------------------------------------------
    // Cycle timer
    // ------------------------------------------------------------
    sfc_timer_if tif ();

    sfc_cycle_timer u_timer (
        .clk(CLK_IN),
        .rst_n(NRST_IN),
        .tif(tif.timer)
    );

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    sfc_state_type state_q, state_d;
    logic [7:0] shift_q, shift_d, opcode_q, opcode_d, arg_q, arg_d;
    logic [2:0] bit_idx_q, bit_idx_d, byte_cnt_q, byte_cnt_d, out_idx_q, out_idx_d;
    logic wel_q, wel_d, dout_q, dout_d, oe_q, oe_d;
    logic [5:0] prot_q, prot_d;
    logic [7:0] status_byte, new_byte;
    logic start;
    logic [TIME_W-1:0] load_us;

    assign status_byte = {prot_q, wel_q, tif.busy};

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        opcode_d = opcode_q;
        arg_d = arg_q;
        bit_idx_d = bit_idx_q;
        byte_cnt_d = byte_cnt_q;
        out_idx_d = out_idx_q;
        wel_d = wel_q;
        dout_d = dout_q;
        oe_d = oe_q;
        prot_d = prot_q;
        start = 1'b0;
        load_us = '0;
        new_byte = {shift_q[6:0], sync2_q[SYN_DIN]};
        if (sel_fall) begin
            state_d = ST_COMMAND;
            bit_idx_d = '0;
            byte_cnt_d = '0;
            out_idx_d = '0;
        end else if (sel_low && sclk_rise && state_q == ST_COMMAND) begin
            shift_d = new_byte;
            bit_idx_d = bit_idx_q + 1'b1;
            if (bit_idx_q == BIT_LAST) begin
                // Counter saturates: long page writes only need to prove a data byte came
                if (byte_cnt_q != BYTES_WRITE_MIN) begin
                    byte_cnt_d = byte_cnt_q + 1'b1;
                end
                if (byte_cnt_q == '0) begin
                    opcode_d = new_byte;
                    if (new_byte == OP_READ_STATUS) begin
                        state_d = ST_STATUS_OUT;
                    end
                end else if (byte_cnt_q == BYTES_OPCODE_ONLY) begin
                    arg_d = new_byte;
                end
            end
        end else if (sel_low && sclk_fall && state_q == ST_STATUS_OUT) begin
            // Status repeats for as long as the host keeps clocking
            dout_d = status_byte[BIT_LAST - out_idx_q];
            out_idx_d = out_idx_q + 1'b1;
            oe_d = 1'b1;
        end
        if (sel_rise) begin
            oe_d = 1'b0;
            state_d = ST_COMMAND;
            // Partial bytes or a running cycle cancel write-type commands
            if (bit_idx_q == '0 && !tif.busy) begin
                if (opcode_q == OP_WRITE_ENABLE && byte_cnt_q == BYTES_OPCODE_ONLY) begin
                    wel_d = 1'b1;
                end else if (opcode_q == OP_WRITE_DISABLE && byte_cnt_q == BYTES_OPCODE_ONLY) begin
                    wel_d = 1'b0;
                end else if (wel_q) begin
                    if (opcode_q == OP_WRITE_STATUS && byte_cnt_q == BYTES_STATUS_WRITE) begin
                        start = 1'b1;
                        load_us = STATUS_WRITE_US;
                        prot_d = arg_q[7:STAT_PROT_LSB];
                    end else if (opcode_q == OP_WRITE_BYTES && byte_cnt_q == BYTES_WRITE_MIN) begin
                        start = 1'b1;
                        load_us = PAGE_PROGRAM_US;
                    end else if (opcode_q == OP_ERASE_BULK && byte_cnt_q == BYTES_OPCODE_ONLY) begin
                        start = 1'b1;
                        load_us = FULL_ERASE_US;
                    end else if (opcode_q == OP_ERASE_SECTOR && byte_cnt_q >= BYTES_SECTOR_ERASE) begin
                        start = 1'b1;
                        load_us = SECTOR_ERASE_US;
                    end
                    if (start) begin
                        wel_d = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_q <= ST_COMMAND;
            shift_q <= 8'h00;
            opcode_q <= 8'h00;
            arg_q <= 8'h00;
            bit_idx_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            out_idx_q <= 3'h0;
            wel_q <= 1'b0;
            dout_q <= 1'b0;
            oe_q <= 1'b0;
            prot_q <= PROT_RESET;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            opcode_q <= opcode_d;
            arg_q <= arg_d;
            bit_idx_q <= bit_idx_d;
            byte_cnt_q <= byte_cnt_d;
            out_idx_q <= out_idx_d;
            wel_q <= wel_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
            prot_q <= prot_d;
        end
    end

    assign tif.start = start;
    assign tif.load_us = load_us;

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign DATA_OUT = dout_q;
    assign DATA_OE_OUT = oe_q;
    assign ACTIVE_POWER_OUT = sel_low | tif.busy;
    assign WRITE_IN_PROGRESS_OUT = tif.busy;
    assign WRITE_ENABLE_LATCH_OUT = wel_q;
endmodule // sfc_flash_seq

// *** hdl/sfc_pkg.sv ***
// Constants shared by the serial configuration flash cycle sequencer
package sfc_pkg;
    // ------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------
    localparam int CLK_RATE_HZ = 100_000_000;
    localparam int HZ_PER_MHZ = 1_000_000;
    localparam int CYCLES_PER_US = CLK_RATE_HZ / HZ_PER_MHZ;
    localparam int US_PER_MS = 1000;
    localparam int US_PER_S = 1_000_000;
    localparam int TIME_W = 28;
    localparam int DIV_W = 8;

    // ------------------------------------------------------------
    // Self-timed cycle durations, indexed smallest density first
    // ------------------------------------------------------------
    localparam int DENSITY_COUNT = 5;
    localparam int LARGEST_DENSITY = 4;
    localparam real PAGE_PROGRAM_TYP_SMALL_MS = 1.5;
    localparam real PAGE_PROGRAM_MAX_SMALL_MS = 5.0;
    localparam real PAGE_PROGRAM_TYP_LARGE_MS = 2.5;
    localparam real PAGE_PROGRAM_MAX_LARGE_MS = 7.0;
    localparam int STATUS_WRITE_TYP_MS = 5;
    localparam int STATUS_WRITE_MAX_MS = 15;
    localparam int FULL_ERASE_TYP_S [DENSITY_COUNT] = '{3, 5, 17, 68, 105};
    localparam int FULL_ERASE_MAX_S [DENSITY_COUNT] = '{6, 10, 40, 160, 250};
    localparam int SECTOR_ERASE_TYP_S = 2;
    localparam int SECTOR_ERASE_MAX_SMALL_S = 3;
    localparam int SECTOR_ERASE_MAX_LARGE_S = 6;

    // ------------------------------------------------------------
    // Operation codes, MSB first on the serial input
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_WRITE_BYTES = 8'h02;
    localparam logic [7:0] OP_ERASE_BULK = 8'hC7;
    localparam logic [7:0] OP_ERASE_SECTOR = 8'hD8;

    // ------------------------------------------------------------
    // Framing: whole bytes needed by each command
    // ------------------------------------------------------------
    localparam logic [2:0] BYTES_OPCODE_ONLY = 3'h1;
    localparam logic [2:0] BYTES_STATUS_WRITE = 3'h2;
    localparam logic [2:0] BYTES_SECTOR_ERASE = 3'h4;
    localparam logic [2:0] BYTES_WRITE_MIN = 3'h5;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Status byte: bit 0 busy, bit 1 write enable latch, rest protection
    localparam int STAT_PROT_LSB = 2;
    localparam logic [5:0] PROT_RESET = 6'h00;

    // Synchroniser lanes
    // Reset to the idle pin levels, select high and clock low, so no false edge follows reset
    localparam int SYN_SEL = 0;
    localparam int SYN_CLK = 1;
    localparam int SYN_DIN = 2;
    localparam int SYN_W = 3;
    localparam logic [SYN_W-1:0] SYN_RESET = 3'h1;

    typedef enum logic [1:0] {ST_COMMAND, ST_STATUS_OUT} sfc_state_type;
endpackage

// *** hdl/sfc_timer_if.sv ***
// Handshake between the command sequencer and the cycle timer
`timescale 1ns/1ps
interface sfc_timer_if;
    import sfc_pkg::*;
    logic start;
    logic [TIME_W-1:0] load_us;
    logic busy;
    modport seq (output start, output load_us, input busy);
    modport timer (input start, input load_us, output busy);
endinterface

// *** hdl/sfc_cycle_timer.sv ***
// Microsecond down-counter that times one self-timed internal cycle
`timescale 1ns/1ps
module sfc_cycle_timer
    import sfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    sfc_timer_if.timer tif
);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLES_PER_US - 1);
    logic [DIV_W-1:0] div_q, div_d;
    logic [TIME_W-1:0] remain_q, remain_d;
    logic tick;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        div_d = div_q;
        remain_d = remain_q;
        tick = (div_q == DIV_LAST);
        if (tif.start) begin
            // Restart the divider so the cycle never runs short by a part tick
            div_d = '0;
            remain_d = tif.load_us;
        end else if (remain_q != '0) begin
            div_d = tick ? '0 : div_q + 1'b1;
            if (tick) begin
                remain_d = remain_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
            remain_q <= '0;
        end else begin
            div_q <= div_d;
            remain_q <= remain_d;
        end
    end

    assign tif.busy = (remain_q != '0);
endmodule // sfc_cycle_timer

// *** tb/sfc_flash_seq_asserts.sv ***
// Port-level checks for the flash cycle sequencer
`timescale 1ns/1ps
module sfc_flash_seq_asserts
    import sfc_pkg::*;
#(
    parameter logic [TIME_W-1:0] PAGE_PROGRAM_US = 28'h1,
    parameter logic [TIME_W-1:0] STATUS_WRITE_US = 28'h1,
    parameter logic [TIME_W-1:0] FULL_ERASE_US = 28'h1,
    parameter logic [TIME_W-1:0] SECTOR_ERASE_US = 28'h1
) (
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic MEMORY_SELECT_N_IN,
    input wire logic DATA_OE_OUT,
    input wire logic ACTIVE_POWER_OUT,
    input wire logic WRITE_IN_PROGRESS_OUT,
    input wire logic WRITE_ENABLE_LATCH_OUT
);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    localparam logic [TIME_W-1:0] M_A = (PAGE_PROGRAM_US > STATUS_WRITE_US) ? PAGE_PROGRAM_US : STATUS_WRITE_US;
    localparam logic [TIME_W-1:0] M_B = (FULL_ERASE_US > SECTOR_ERASE_US) ? FULL_ERASE_US : SECTOR_ERASE_US;
    // Two spare cycles absorb the start and stop lag of the timer
    localparam longint MAX_CYC = longint'(CYCLES_PER_US) * longint'((M_A > M_B) ? M_A : M_B) + 2;
    logic [39:0] busy_cnt_q, busy_cnt_d;
    logic [3:0] hi_cnt_q, hi_cnt_d;
    always_comb begin
        busy_cnt_d = WRITE_IN_PROGRESS_OUT ? busy_cnt_q + 40'h1 : 40'h0;
        hi_cnt_d = !MEMORY_SELECT_N_IN ? 4'h0 : ((hi_cnt_q == 4'hF) ? hi_cnt_q : hi_cnt_q + 4'h1);
    end
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            busy_cnt_q <= 40'h0;
            hi_cnt_q <= 4'hF;
        end else begin
            busy_cnt_q <= busy_cnt_d;
            hi_cnt_q <= hi_cnt_d;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    property p_active_sel; !MEMORY_SELECT_N_IN [*3] |-> ACTIVE_POWER_OUT; endproperty
    a_active_sel: assert property (p_active_sel) else $error("not active while selected");
    property p_oe_off; hi_cnt_q >= 4'h6 |-> !DATA_OE_OUT; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
    property p_active_busy; WRITE_IN_PROGRESS_OUT |-> ACTIVE_POWER_OUT; endproperty
    a_active_busy: assert property (p_active_busy) else $error("standby during cycle");
    property p_standby;
        hi_cnt_q >= 4'h8 && !WRITE_IN_PROGRESS_OUT && !$past(WRITE_IN_PROGRESS_OUT) |-> !ACTIVE_POWER_OUT;
    endproperty
    a_standby: assert property (p_standby) else $error("active with nothing pending");
    property p_busy_max; busy_cnt_q <= MAX_CYC; endproperty
    a_busy_max: assert property (p_busy_max) else $error("cycle too long");
    property p_wip_start; $rose(WRITE_IN_PROGRESS_OUT) |-> MEMORY_SELECT_N_IN && hi_cnt_q <= 4'h8; endproperty
    a_wip_start: assert property (p_wip_start) else $error("cycle not started at deselect");
    property p_wel_clear; $rose(WRITE_IN_PROGRESS_OUT) |-> ##[0:2] !WRITE_ENABLE_LATCH_OUT; endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared");
    property p_wel_hold; WRITE_IN_PROGRESS_OUT && !WRITE_ENABLE_LATCH_OUT |=> !WRITE_ENABLE_LATCH_OUT; endproperty
    a_wel_hold: assert property (p_wel_hold) else $error("latch set while busy");
    c_done: cover property ($fell(WRITE_IN_PROGRESS_OUT));
    c_wel: cover property ($rose(WRITE_ENABLE_LATCH_OUT));
    c_read: cover property (DATA_OE_OUT && WRITE_IN_PROGRESS_OUT);
endmodule // sfc_flash_seq_asserts

bind sfc_flash_seq sfc_flash_seq_asserts #(.PAGE_PROGRAM_US(PAGE_PROGRAM_US), .STATUS_WRITE_US(STATUS_WRITE_US),
    .FULL_ERASE_US(FULL_ERASE_US), .SECTOR_ERASE_US(SECTOR_ERASE_US)) i_chk (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
    .MEMORY_SELECT_N_IN(MEMORY_SELECT_N_IN), .DATA_OE_OUT(DATA_OE_OUT), .ACTIVE_POWER_OUT(ACTIVE_POWER_OUT),
    .WRITE_IN_PROGRESS_OUT(WRITE_IN_PROGRESS_OUT), .WRITE_ENABLE_LATCH_OUT(WRITE_ENABLE_LATCH_OUT));

// *** tb/sfc_host_model.sv ***
// Host model that frames commands on the serial pins
`timescale 1ns/1ps
module sfc_host_model (
    input wire logic clk,
    output logic sel_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    // Half period of 8 cycles plus one extra low cycle: 170 ns per bit, inside every clock limit
    localparam int HALF = 8;
    // Restart line of the configuring host; the block has no pin for it
    logic restart_n = 1'b1;
    // Raw image data bytes go LSB first; opcode and address stay MSB first
    logic raw_lsb = 1'b0;
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Clock stands low outside frames; idle data toggles so stale bits never look valid
    task automatic xfer(input logic [7:0] b [5], input int n, input int nrd, output logic [7:0] rd);
        rd = 8'h00;
        repeat (2 * HALF) @(posedge clk);
        sel_n <= 1'b0;
        repeat (HALF) @(posedge clk);
        for (int i = 0; i < 8 * (n + nrd); i++) begin
            sdi <= (i < 8 * n) ? b[i / 8][(raw_lsb && i >= 32) ? i % 8 : 7 - i % 8] : ~sdi;
            repeat (HALF) @(posedge clk);
            if (i >= 8 * n) rd = {rd[6:0], sdo};
            sclk <= 1'b1;
            repeat (HALF) @(posedge clk);
            sclk <= 1'b0;
            @(posedge clk);
        end
        sel_n <= 1'b1;
        sdi <= ~sdi;
    endtask
    // Reconfiguration: an empty select pulse with a restart pulse; nothing may start
    task automatic recover();
        repeat (2 * HALF) @(posedge clk);
        sel_n <= 1'b0;
        restart_n <= 1'b0;
        repeat (HALF) @(posedge clk);
        sel_n <= 1'b1;
        restart_n <= 1'b1;
    endtask
    // Cable session: hold the configuring host in reset, then release and pulse restart
    task automatic cable(input logic on);
        @(posedge clk);
        if (on) begin
            restart_n <= 1'b0;
        end else begin
            restart_n <= 1'b1;
            repeat (HALF) @(posedge clk);
            restart_n <= 1'b0;
            repeat (HALF) @(posedge clk);
            restart_n <= 1'b1;
        end
    endtask
endmodule // sfc_host_model

// *** tb/tb_top.sv ***
// Self-checking bench for the flash cycle sequencer
`timescale 1ns/1ps
module tb_top;
    import sfc_pkg::*;
    localparam int PP = 3, SW = 4, FE = 6, SE = 5;
    logic clk = 1'b0, nrst = 1'b0;
    logic sel_n, sclk, sdi, dout, doe, act, wip, wel;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    logic [7:0] rd;
    sfc_flash_seq #(.PAGE_PROGRAM_US(TIME_W'(PP)), .STATUS_WRITE_US(TIME_W'(SW)), .FULL_ERASE_US(TIME_W'(FE)),
        .SECTOR_ERASE_US(TIME_W'(SE))) i_dut (.CLK_IN(clk), .NRST_IN(nrst), .MEMORY_SELECT_N_IN(sel_n),
        .SERIAL_CLOCK_LINE_IN(sclk), .SERIAL_IN_LINE_IN(sdi), .DATA_OUT(dout), .DATA_OE_OUT(doe),
        .ACTIVE_POWER_OUT(act), .WRITE_IN_PROGRESS_OUT(wip), .WRITE_ENABLE_LATCH_OUT(wel));
    // A released data line shows the inverse of its last bit, so a read outside enable fails
    sfc_host_model i_host (.clk(clk), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(doe ? dout : ~dout));
    always #5 clk = ~clk;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic t_wren();
        i_host.xfer('{8'h06, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 0, rd);
        repeat (6) @(negedge clk);
        check({7'h0, wel}, 8'h01, "latch not set");
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 1000 && wip !== 1'b0; k++) @(negedge clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_refuse();
        t_wren();
        i_host.recover();
        repeat (6) @(negedge clk);
        check({5'h0, doe, act, wip, wel}, 8'h01, "empty frame acted on");
        i_host.xfer('{8'h04, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 0, rd);
        repeat (6) @(negedge clk);
        check({7'h0, wel}, 8'h00, "latch not cleared by disable");
        i_host.xfer('{8'hC7, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 0, rd);
        repeat (20) @(negedge clk);
        check({6'h0, act, wip}, 8'h00, "erase ran without latch");
        $display("test refuse done");
    endtask
    task automatic t_cycle(input logic [7:0] b [5], input int n, input int us, input string nm);
        int k;
        t_wren();
        i_host.xfer(b, n, 0, rd);
        for (k = 0; k < 10 && wip !== 1'b1; k++) @(negedge clk);
        check({6'h0, act, wip}, 8'h03, "cycle did not start");
        check({7'h0, wel}, 8'h00, "latch kept in cycle");
        for (k = 0; k < 2 * us * CYCLES_PER_US && wip === 1'b1; k++) @(negedge clk);
        check({7'h0, k >= us * CYCLES_PER_US - 3 && k <= us * CYCLES_PER_US + 2}, 8'h01, nm);
        repeat (5) @(negedge clk);
        check({7'h0, act}, 8'h00, "no standby after cycle");
        $display("test %s done", nm);
    endtask
    task automatic t_poll();
        t_wren();
        i_host.xfer('{8'hC7, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 0, rd);
        i_host.xfer('{8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 1, rd);
        check(rd, 8'h01, "busy bit not read");
        @(negedge clk);
        check({7'h0, doe}, 8'h01, "status not driven");
        repeat (4) @(negedge clk);
        check({7'h0, doe}, 8'h00, "output left driven");
        i_host.xfer('{8'h06, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 0, rd);
        repeat (6) @(negedge clk);
        check({7'h0, wel}, 8'h00, "latch set while busy");
        wait_idle();
        i_host.xfer('{8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 1, rd);
        check(rd, 8'h00, "busy bit after cycle");
        $display("test poll done");
    endtask
    task automatic t_readback();
        i_host.xfer('{8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 1, rd);
        check(rd, 8'h54, "status readback");
        $display("test readback done");
    endtask
    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check({3'h0, doe, dout, act, wip, wel}, 8'h00, "reset outputs");
        t_refuse();
        i_host.cable(1'b1);
        i_host.raw_lsb = 1'b1;
        t_cycle('{8'h02, 8'h00, 8'h01, 8'h00, 8'hA5}, 5, PP, "program");
        i_host.raw_lsb = 1'b0;
        t_cycle('{8'hD8, 8'h01, 8'h00, 8'h00, 8'h00}, 4, SE, "sector");
        t_cycle('{8'hC7, 8'h00, 8'h00, 8'h00, 8'h00}, 1, FE, "bulk");
        t_poll();
        t_cycle('{8'h01, 8'h54, 8'h00, 8'h00, 8'h00}, 2, SW, "status write");
        i_host.cable(1'b0);
        t_readback();
        conclude();
    end
endmodule // tb_top
